// >>> design/adc_input_route.sv
// Purpose: decode source and channel fields into multiplexer switches
// Assumes: fields come from registers on the same clock
// Notes: purely combinational, the top registers the result
module adc_input_route (
   input wire logic [2:0] src_in,
   input wire logic [2:0] chan_in,
   output adc_sel_pkg::route_type route_out
);
   logic ext_sel; // an external pin is the source
   logic [2:0] int_idx; // index of the internal level
   logic [7:0] int_hot; // one-hot of that index, top two unused

   // internal level wins; external switches all open then
   always_comb begin
      ext_sel = (src_in == adc_sel_pkg::SRC_EXT_A) ||
                (src_in == adc_sel_pkg::SRC_EXT_B);
      // 001..011 supply levels, 101..111 reference levels
      if (src_in[2]) begin
         int_idx = 3'h2 + {1'b0, src_in[1:0]};
      end else begin
         int_idx = {1'b0, src_in[1:0]} - 3'h1;
      end
      int_hot = adc_sel_pkg::dec3(int_idx);
      route_out.ext = 8'h00;
      route_out.int_src = 6'h00;
      if (ext_sel) begin
         route_out.ext = adc_sel_pkg::dec3(chan_in);
      end else begin
         route_out.int_src = int_hot[5:0];
      end
   end
endmodule

// >>> design/adc_sar_engine.sv
// Purpose: successive approximation sequencer for the shared converter
// Assumes: comparator input already synchronised by the caller
// Notes: dropping the enable aborts a conversion with no result
module adc_sar_engine (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic enable_in,
   input wire logic start_in,
   input wire logic [2:0] clk_sel_in,
   input wire logic comp_in,
   output logic busy_out,
   output logic done_out,
   output logic sample_out,
   output logic [11:0] trial_out,
   output logic [11:0] result_out
);
   adc_sel_pkg::sar_state_type st_q, st_d; // sequencer state
   logic [9:0] cnt_q, cnt_d; // conversion clock divider
   logic [3:0] step_q, step_d; // sample ticks taken
   logic [11:0] bit_q, bit_d; // bit under trial
   logic [11:0] res_q, res_d; // bits decided so far
   logic [9:0] thr; // divider terminal count
   logic tick; // one conversion clock period elapsed

   // next state; the divider is at least four cycles so that the
   // registered code and the two-stage comparator sync settle first
   always_comb begin
      thr = (10'h001 << ({1'b0, clk_sel_in} + adc_sel_pkg::DIV_BASE))
            - 10'h001;
      tick = (cnt_q == thr);
      st_d = st_q;
      cnt_d = cnt_q;
      step_d = step_q;
      bit_d = bit_q;
      res_d = res_q;
      if (st_q != adc_sel_pkg::SAR_IDLE) begin
         cnt_d = tick ? 10'h000 : cnt_q + 10'h001;
      end
      case (st_q)
         adc_sel_pkg::SAR_IDLE: begin
            if (start_in && enable_in) begin
               st_d = adc_sel_pkg::SAR_SAMPLE;
               cnt_d = 10'h000;
               step_d = 4'h0;
               res_d = 12'h000;
               bit_d = adc_sel_pkg::MSB_TRIAL;
            end
         end
         adc_sel_pkg::SAR_SAMPLE: begin
            if (tick) begin
               step_d = step_q + 4'h1;
               if (step_q == adc_sel_pkg::SAMPLE_TICKS - 4'h1) begin
                  st_d = adc_sel_pkg::SAR_CONV;
               end
            end
         end
         adc_sel_pkg::SAR_CONV: begin
            // keep the trial bit when the input is above the code
            if (tick) begin
               if (comp_in) begin
                  res_d = res_q | bit_q;
               end
               bit_d = bit_q >> 1;
               if (bit_q[0]) begin
                  st_d = adc_sel_pkg::SAR_DONE;
               end
            end
         end
         adc_sel_pkg::SAR_DONE: begin
            st_d = adc_sel_pkg::SAR_IDLE;
         end
         default: begin
            st_d = adc_sel_pkg::SAR_IDLE;
         end
      endcase
      if (!enable_in) begin
         st_d = adc_sel_pkg::SAR_IDLE;
      end
   end

   // registers only
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_q <= adc_sel_pkg::SAR_IDLE;
         cnt_q <= 10'h000;
         step_q <= 4'h0;
         bit_q <= 12'h000;
         res_q <= 12'h000;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         step_q <= step_d;
         bit_q <= bit_d;
         res_q <= res_d;
      end
   end

   assign busy_out = (st_q != adc_sel_pkg::SAR_IDLE);
   assign done_out = (st_q == adc_sel_pkg::SAR_DONE) && enable_in;
   assign sample_out = (st_q == adc_sel_pkg::SAR_SAMPLE);
   assign trial_out = res_q | bit_q;
   assign result_out = res_q;
endmodule

// >>> design/adc_sel_pkg.sv
// Purpose: shared constants, types and helpers for the converter control
// Assumes: 32-bit Avalon-MM data, registers in the low byte of each word
// Notes: offsets are byte addresses, one aligned word per register
package adc_sel_pkg;
   // result width of the single shared converter
   localparam int RES_W = 12;
   // register byte offsets
   localparam logic [4:0] OFF_RES_LOW = 5'h00;
   localparam logic [4:0] OFF_RES_HIGH = 5'h04;
   localparam logic [4:0] OFF_CTL_A = 5'h08;
   localparam logic [4:0] OFF_CTL_B = 5'h0C;
   localparam logic [4:0] OFF_CTL_C = 5'h10;
   localparam logic [4:0] OFF_PIN_EN = 5'h14;
   // values after reset
   localparam logic [7:0] CTL_A_RST = 8'h00;
   localparam logic [7:0] CTL_B_RST = 8'h00;
   localparam logic [7:0] CTL_C_RST = 8'h00;
   localparam logic [7:0] PIN_EN_RST = 8'h00;
   localparam logic [11:0] RESULT_RST = 12'h000;
   // writable bit masks of the control words
   localparam logic [7:0] CTL_A_WMASK = 8'h37;
   localparam logic [7:0] CTL_B_WMASK = 8'hE7;
   // sample phase length in conversion clock ticks
   localparam logic [3:0] SAMPLE_TICKS = 4'h4;
   // conversion clock divides by 2^(field + DIV_BASE)
   localparam logic [3:0] DIV_BASE = 4'h2;
   // first trial bit of the approximation
   localparam logic [11:0] MSB_TRIAL = 12'h800;
   // input source codes that route an external pin
   localparam logic [2:0] SRC_EXT_A = 3'h0;
   localparam logic [2:0] SRC_EXT_B = 3'h4;

   typedef enum logic [1:0] {
      SAR_IDLE = 2'b00,
      SAR_SAMPLE = 2'b01,
      SAR_CONV = 2'b10,
      SAR_DONE = 2'b11
   } sar_state_type;

   typedef struct packed {
      logic start;
      logic conversion_busy_flag;
      logic converter_enable_bit;
      logic result_format_sel;
      logic rsvd;
      logic [2:0] external_channel_field;
   } ctl_a_type;

   typedef struct packed {
      logic [2:0] input_source_field;
      logic [1:0] rsvd;
      logic [2:0] conversion_clock_field;
   } ctl_b_type;

   // one-hot switch settings of the input multiplexer
   typedef struct packed {
      logic [7:0] ext;
      logic [5:0] int_src;
   } route_type;

   // three-bit code to one-hot byte
   function automatic logic [7:0] dec3(input logic [2:0] v);
      dec3 = 8'h01 << v;
   endfunction

   // 12-bit result into the 16-bit byte pair, left or right justified
   function automatic logic [15:0] fmt_result(input logic [11:0] r,
                                              input logic f);
      if (f) begin
         fmt_result = {4'h0, r};
      end else begin
         fmt_result = {r, 4'h0};
      end
   endfunction
endpackage

// >>> design/adc_select_top.sv
// Purpose: control, input selection and result format of the converter
// Assumes: Avalon-MM master holds each request until waitrequest is low
// Notes: the analog comparator and switches live outside this block

// Overview of operation
// - one shared converter, one input mux
// - internal source wins, external switches open
// - format bit picks left or right justify
// - bits without result data read zero
// - disabled converter keeps result registers
// - source 000/100 routes pin chosen by channel
// - other source codes route supply or reference
// - pin enable makes pin analog input
// - analog pin loses its pull-high
module adc_select_top (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic [4:0] ADDRESS_IN,
   input wire logic READ_IN,
   input wire logic WRITE_IN,
   input wire logic [31:0] WRITEDATA_IN,
   output logic [31:0] READDATA_OUT,
   output logic WAITREQUEST_OUT,
   input wire logic COMP_IN,
   output logic [11:0] DAC_CODE_OUT,
   output logic SAMPLE_OUT,
   output logic CONV_POWER_OUT,
   output logic [7:0] EXT_CHAN_SEL_OUT,
   output logic [5:0] INT_SRC_SEL_OUT,
   output logic [7:0] PIN_ANALOG_OUT,
   output logic [7:0] PULLUP_DISABLE_OUT,
   output logic [7:0] REF_CTRL_OUT
);
   // software visible state
   adc_sel_pkg::ctl_a_type ctl_a_q, ctl_a_d; // control word a
   adc_sel_pkg::ctl_b_type ctl_b_q, ctl_b_d; // control word b
   logic [7:0] ctl_c_q, ctl_c_d; // reference controls, passed out
   logic [7:0] pin_en_q, pin_en_d; // analog_pin_enable_bits
   logic [11:0] result_q, result_d; // last stored conversion
   // bus slave state
   logic wait_q, wait_d; // waitrequest, high unless answering
   logic [31:0] rdata_q, rdata_d; // read data, valid with wait low
   logic start_q, start_d; // one-cycle start to the sequencer
   // registered pin side
   logic sync1_q, sync2_q; // comparator synchroniser
   logic [11:0] dac_q; // code to the converter DAC
   logic sample_q; // sample switch closed
   logic power_q; // converter powered
   adc_sel_pkg::route_type route_q; // switch settings
   logic [7:0] analog_q; // pins in analog use
   // internal nets
   adc_sel_pkg::route_type route_c; // decoded switch settings
   logic sar_busy; // sequencer running
   logic sar_done; // result ready this cycle
   logic sar_sample; // sequencer in sample phase
   logic [11:0] sar_trial; // trial code
   logic [11:0] sar_result; // approximation result
   logic [15:0] res_pair; // formatted byte pair
   logic [7:0] rd_byte; // byte selected by the address
   logic req; // read or write present
   logic [7:0] wbyte; // written byte

   // decode the mux from the programmed source and channel
   // external pin by channel
   adc_input_route u_route (
      .src_in(ctl_b_q.input_source_field),
      .chan_in(ctl_a_q.external_channel_field),
      .route_out(route_c)
   );

   // the single sequencer shared by every source; dropping the enable
   // bit aborts it so a half-built code never reaches the result
   adc_sar_engine u_sar (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .enable_in(ctl_a_q.converter_enable_bit),
      .start_in(start_q),
      .clk_sel_in(ctl_b_q.conversion_clock_field),
      .comp_in(sync2_q),
      .busy_out(sar_busy),
      .done_out(sar_done),
      .sample_out(sar_sample),
      .trial_out(sar_trial),
      .result_out(sar_result)
   );

   // read side: format and select the addressed byte
   always_comb begin
      res_pair = adc_sel_pkg::fmt_result(result_q,
                                         ctl_a_q.result_format_sel);
      case (ADDRESS_IN)
         adc_sel_pkg::OFF_RES_LOW: begin
            rd_byte = res_pair[7:0];
         end
         adc_sel_pkg::OFF_RES_HIGH: begin
            rd_byte = res_pair[15:8];
         end
         adc_sel_pkg::OFF_CTL_A: begin
            rd_byte = {1'b0, sar_busy | start_q, ctl_a_q[5:0]};
         end
         adc_sel_pkg::OFF_CTL_B: begin
            rd_byte = ctl_b_q;
         end
         adc_sel_pkg::OFF_CTL_C: begin
            rd_byte = ctl_c_q;
         end
         adc_sel_pkg::OFF_PIN_EN: begin
            rd_byte = pin_en_q;
         end
         default: begin
            // unmapped words read zero
            rd_byte = 8'h00;
         end
      endcase
   end

   // next values of the bus slave and the registers; every access
   // gets one wait cycle and the read byte is latched when taken, so
   // a result stored during the wait shows on the next read only
   always_comb begin
      req = READ_IN || WRITE_IN;
      wbyte = WRITEDATA_IN[7:0];
      ctl_a_d = ctl_a_q;
      ctl_b_d = ctl_b_q;
      ctl_c_d = ctl_c_q;
      pin_en_d = pin_en_q;
      result_d = result_q;
      wait_d = 1'b1;
      rdata_d = rdata_q;
      start_d = 1'b0;
      // one wait cycle, then answer for a single cycle
      if (req && wait_q) begin
         wait_d = 1'b0;
         rdata_d = READ_IN ? {24'h000000, rd_byte} : 32'h00000000;
      end
      // a write takes effect at the edge where its waitrequest is sampled low
      if (WRITE_IN && !wait_q) begin
         case (ADDRESS_IN)
            adc_sel_pkg::OFF_CTL_A: begin
               ctl_a_d = wbyte & adc_sel_pkg::CTL_A_WMASK;
               // start only when enabled and idle
               start_d = wbyte[7] && wbyte[5] && !sar_busy && !start_q;
            end
            adc_sel_pkg::OFF_CTL_B: begin
               ctl_b_d = wbyte & adc_sel_pkg::CTL_B_WMASK;
            end
            adc_sel_pkg::OFF_CTL_C: begin
               ctl_c_d = wbyte;
            end
            adc_sel_pkg::OFF_PIN_EN: begin
               pin_en_d = wbyte;
            end
            default: begin
               // result bytes and unmapped words ignore writes
               ctl_c_d = ctl_c_q;
            end
         endcase
      end
      if (sar_done && ctl_a_q.converter_enable_bit) begin
         result_d = sar_result;
      end
   end

   // register the bus slave and software state
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         ctl_a_q <= adc_sel_pkg::CTL_A_RST;
         ctl_b_q <= adc_sel_pkg::CTL_B_RST;
         ctl_c_q <= adc_sel_pkg::CTL_C_RST;
         pin_en_q <= adc_sel_pkg::PIN_EN_RST;
         result_q <= adc_sel_pkg::RESULT_RST;
         wait_q <= 1'b1;
         rdata_q <= 32'h00000000;
         start_q <= 1'b0;
      end else begin
         ctl_a_q <= ctl_a_d;
         ctl_b_q <= ctl_b_d;
         ctl_c_q <= ctl_c_d;
         pin_en_q <= pin_en_d;
         result_q <= result_d;
         wait_q <= wait_d;
         rdata_q <= rdata_d;
         start_q <= start_d;
      end
   end

   // pin side registers; every pin output except REF_CTRL_OUT comes from here
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         dac_q <= 12'h000;
         sample_q <= 1'b0;
         power_q <= 1'b0;
         route_q <= '0;
         analog_q <= 8'h00;
      end else begin
         // comparator is asynchronous to the clock
         sync1_q <= COMP_IN;
         sync2_q <= sync1_q;
         // one trial code for all sources
         dac_q <= sar_trial;
         sample_q <= sar_sample;
         power_q <= ctl_a_q.converter_enable_bit;
         route_q <= route_c;
         analog_q <= pin_en_q;
      end
   end

   assign READDATA_OUT = rdata_q;
   assign WAITREQUEST_OUT = wait_q;
   assign DAC_CODE_OUT = dac_q;
   assign SAMPLE_OUT = sample_q;
   assign CONV_POWER_OUT = power_q;
   assign EXT_CHAN_SEL_OUT = route_q.ext;
   assign INT_SRC_SEL_OUT = route_q.int_src;
   assign PIN_ANALOG_OUT = analog_q;
   assign PULLUP_DISABLE_OUT = analog_q;
   assign REF_CTRL_OUT = ctl_c_q;

   // checks; helpers name the read capture edge and an external source
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   logic rd_cap; // read captured into the read data this edge
   logic is_ext; // programmed source is an external pin
   assign rd_cap = READ_IN && wait_q;
   assign is_ext = (ctl_b_q.input_source_field == adc_sel_pkg::SRC_EXT_A)
                || (ctl_b_q.input_source_field == adc_sel_pkg::SRC_EXT_B);

   route_int_a: assert property (
      !is_ext |=> (EXT_CHAN_SEL_OUT == 8'h00) && (INT_SRC_SEL_OUT != 6'h00))
      else $error("external switch closed with internal source");
   route_ext_a: assert property (
      is_ext |=> EXT_CHAN_SEL_OUT ==
         adc_sel_pkg::dec3($past(ctl_a_q.external_channel_field)))
      else $error("wrong external channel switch");
   route_ref_a: assert property (
      (ctl_b_q.input_source_field == 3'h5) |=> INT_SRC_SEL_OUT == 6'h08)
      else $error("reference level not routed");
   fmt_left_a: assert property (
      rd_cap && ADDRESS_IN == adc_sel_pkg::OFF_RES_HIGH &&
      !ctl_a_q.result_format_sel
      |=> READDATA_OUT == {24'h0, $past(result_q[11:4])})
      else $error("left justified high byte wrong");
   zero_bits_a: assert property (
      rd_cap && ADDRESS_IN == adc_sel_pkg::OFF_RES_HIGH &&
      ctl_a_q.result_format_sel |=> READDATA_OUT[31:4] == 28'h0)
      else $error("unused result bits not zero");
   hold_dis_a: assert property (
      !ctl_a_q.converter_enable_bit |=> $stable(result_q))
      else $error("result changed while disabled");
   pin_analog_a: assert property (
      $changed(pin_en_q) |=> PIN_ANALOG_OUT == $past(pin_en_q))
      else $error("pin analog select lags");
   pullup_off_a: assert property (
      PULLUP_DISABLE_OUT == PIN_ANALOG_OUT)
      else $error("pull-high left on analog pin");
   busy_run_a: assert property (
      start_q |-> sar_busy == 1'b0 ##1 sar_busy[*2])
      else $error("start did not make converter busy");
   store_a: assert property (
      sar_done |=> result_q == $past(sar_result))
      else $error("result not stored at end of conversion");

   // the low byte in both formats; a swapped nibble order would
   // still pass the high byte checks
   fmt_right_a: assert property (
      rd_cap && ADDRESS_IN == adc_sel_pkg::OFF_RES_LOW &&
      ctl_a_q.result_format_sel
      |=> READDATA_OUT == {24'h0, $past(result_q[7:0])})
      else $error("right justified low byte wrong");
   zero_low_a: assert property (
      rd_cap && ADDRESS_IN == adc_sel_pkg::OFF_RES_LOW &&
      !ctl_a_q.result_format_sel
      |=> READDATA_OUT == {24'h0, $past(result_q[3:0]), 4'h0})
      else $error("left justified low byte wrong");
   // a start with the converter off would run a lost conversion
   start_en_a: assert property (
      start_q |-> ctl_a_q.converter_enable_bit)
      else $error("start issued while converter disabled");
   busy_read_a: assert property (
      rd_cap && ADDRESS_IN == adc_sel_pkg::OFF_CTL_A && sar_busy
      |=> READDATA_OUT[6])
      else $error("busy flag reads low during conversion");
   power_follow_a: assert property (
      CONV_POWER_OUT == $past(ctl_a_q.converter_enable_bit))
      else $error("converter power does not follow enable");

   // covers: full run, internal source, right format, abort
   conv_done_c: cover property (start_q ##[1:200] sar_done);
   int_conv_c: cover property (!is_ext && sar_done);
   fmt_right_c: cover property (rd_cap && ctl_a_q.result_format_sel);
   abort_c: cover property (sar_busy && !ctl_a_q.converter_enable_bit);
endmodule

// >>> verif/adc_input_select_result_format_tb_top.sv
// Purpose: self-checking bench for the converter control block
// Assumes: one wait cycle per bus access, conversion field kept small
// Notes: expected values come from a plain integer model of the registers
module adc_input_select_result_format_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK_IN = 1'b0;
   logic RST_IN = 1'b1;
   logic [4:0] ADDRESS_IN = 5'h00;
   logic READ_IN = 1'b0;
   logic WRITE_IN = 1'b0;
   logic [31:0] WRITEDATA_IN = 32'h0;
   logic [31:0] READDATA_OUT;
   logic WAITREQUEST_OUT;
   logic COMP_IN;
   logic [11:0] DAC_CODE_OUT;
   logic SAMPLE_OUT;
   logic CONV_POWER_OUT;
   logic [7:0] EXT_CHAN_SEL_OUT;
   logic [5:0] INT_SRC_SEL_OUT;
   logic [7:0] PIN_ANALOG_OUT;
   logic [7:0] PULLUP_DISABLE_OUT;
   logic [7:0] REF_CTRL_OUT;
   logic [13:0][11:0] levels = '0; // source levels, pins then internal
   int err_count = 0;
   int n_checks = 0;
   int seed = 59615;
   int m_a, m_b, m_c, m_pin, m_res; // register model
   int s, src, ch, k, n;
   logic [31:0] q;
   logic [7:0] d;
   logic [11:0] lv;
   // 20 MHz system clock
   always #25 CLK_IN = ~CLK_IN;
   adc_select_top dut (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
      .ADDRESS_IN(ADDRESS_IN), .READ_IN(READ_IN), .WRITE_IN(WRITE_IN),
      .WRITEDATA_IN(WRITEDATA_IN), .READDATA_OUT(READDATA_OUT),
      .WAITREQUEST_OUT(WAITREQUEST_OUT), .COMP_IN(COMP_IN),
      .DAC_CODE_OUT(DAC_CODE_OUT), .SAMPLE_OUT(SAMPLE_OUT),
      .CONV_POWER_OUT(CONV_POWER_OUT), .EXT_CHAN_SEL_OUT(EXT_CHAN_SEL_OUT),
      .INT_SRC_SEL_OUT(INT_SRC_SEL_OUT), .PIN_ANALOG_OUT(PIN_ANALOG_OUT),
      .PULLUP_DISABLE_OUT(PULLUP_DISABLE_OUT), .REF_CTRL_OUT(REF_CTRL_OUT));
   adc_source_model src_model (.clk_in(CLK_IN),
      .ext_sel_in(EXT_CHAN_SEL_OUT), .int_sel_in(INT_SRC_SEL_OUT),
      .dac_in(DAC_CODE_OUT), .level_in(levels), .comp_out(COMP_IN));
   // verdict and end of run, also reached by a hang
   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // compare a value read over the bus
   task automatic chk_read(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: read %h expected %h", $time, got, exp);
      end
   endtask
   // compare a value seen on output pins
   task automatic chk_port(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: pins %h expected %h", $time, got, exp);
      end
   endtask
   // one Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [7:0] dat, output logic [31:0] rdat);
      int cnt;
      cnt = 0;
      @(posedge CLK_IN);
      ADDRESS_IN <= a;
      WRITEDATA_IN <= {24'h0, dat};
      READ_IN <= !wr;
      WRITE_IN <= wr;
      do begin
         @(posedge CLK_IN);
         cnt++;
      end while (WAITREQUEST_OUT !== 1'b0 && cnt < 20);
      rdat = READDATA_OUT;
      READ_IN <= 1'b0;
      WRITE_IN <= 1'b0;
      if (WAITREQUEST_OUT !== 1'b0) begin
         err_count++;
         $display("Error at %0t: bus access never answered", $time);
         finish_test();
      end
   endtask
   task automatic wr(input logic [4:0] a, input int dat);
      logic [31:0] dummy;
      bus(1'b1, a, 8'(dat), dummy);
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] rdat);
      bus(1'b0, a, 8'h00, rdat);
   endtask
   // level index of the source that the fields select
   function automatic int src_idx(input int sv, input int cv);
      if (sv == 0 || sv == 4) begin
         return cv;
      end
      return 8 + (sv < 4 ? sv - 1 : sv - 2);
   endfunction
   // expected byte of a stored result in either justification
   function automatic logic [31:0] exp_byte(input int r, input int f,
                                            input int hi);
      int v;
      if (f != 0) begin
         v = hi != 0 ? r >> 8 : r & 255;
      end else begin
         v = hi != 0 ? r >> 4 : (r & 15) << 4;
      end
      return 32'(v & 255);
   endfunction
   // results in the current format against the model
   task automatic chk_results;
      rd(adc_sel_pkg::OFF_RES_LOW, q);
      chk_read(q, exp_byte(m_res, (m_a >> 4) & 1, 0));
      rd(adc_sel_pkg::OFF_RES_HIGH, q);
      chk_read(q, exp_byte(m_res, (m_a >> 4) & 1, 1));
   endtask
   // a hang is cut short here
   initial begin
      repeat (100000) @(posedge CLK_IN);
      err_count++;
      $display("Error at %0t: run did not end in time", $time);
      finish_test();
   end
   // main sequence
   initial begin
      repeat (15) @(posedge CLK_IN);
      @(negedge CLK_IN);
      chk_port(WAITREQUEST_OUT, 1);
      chk_port({REF_CTRL_OUT, PIN_ANALOG_OUT, INT_SRC_SEL_OUT}, 0);
      @(posedge CLK_IN);
      RST_IN <= 1'b0;
      m_a = 0; m_b = 0; m_c = 0; m_pin = 0; m_res = 0;
      // reset values, the last address is unmapped
      for (k = 0; k < 7; k++) begin
         rd(5'(k * 4), q);
         chk_read(q, 0);
      end
      // random control words, refused writes, readback and pins
      repeat (4) begin
         m_b = $random(seed) & 8'hE4; // no start, so clock field 0 or 4
         wr(adc_sel_pkg::OFF_CTL_B, m_b);
         m_c = $random(seed) & 255;
         wr(adc_sel_pkg::OFF_CTL_C, m_c);
         m_pin = $random(seed) & 255;
         wr(adc_sel_pkg::OFF_PIN_EN, m_pin);
         d = 8'($random(seed));
         wr(adc_sel_pkg::OFF_RES_LOW, d);
         wr(adc_sel_pkg::OFF_RES_HIGH, d);
         wr(5'h18, d);
         d = d & 8'h7F; // no start here
         wr(adc_sel_pkg::OFF_CTL_A, d);
         m_a = d & 8'h37;
         rd(adc_sel_pkg::OFF_CTL_A, q);
         chk_read(q, m_a);
         rd(adc_sel_pkg::OFF_CTL_B, q);
         chk_read(q, m_b);
         rd(adc_sel_pkg::OFF_CTL_C, q);
         chk_read(q, m_c);
         rd(adc_sel_pkg::OFF_PIN_EN, q);
         chk_read(q, m_pin);
         rd(5'h18, q);
         chk_read(q, 0);
         chk_results();
         chk_port(PIN_ANALOG_OUT, m_pin);
         chk_port(PULLUP_DISABLE_OUT, m_pin);
         chk_port(REF_CTRL_OUT, m_c);
         chk_port(CONV_POWER_OUT, (m_a >> 5) & 1);
         k = src_idx(m_b >> 5, m_a & 7);
         chk_port({INT_SRC_SEL_OUT, EXT_CHAN_SEL_OUT}, 1 << k);
      end
      // every source code in both formats, edge levels included
      for (s = 0; s < 16; s++) begin
         src = s % 8;
         ch = $random(seed) & 7;
         k = src_idx(src, ch);
         lv = s == 2 ? 12'h000 : s == 13 ? 12'hFFF : 12'($random(seed));
         for (int i = 0; i < 14; i++) begin
            levels[i] <= i == k ? lv : 12'($random(seed));
         end
         m_b = (src << 5) | (s / 8);
         wr(adc_sel_pkg::OFF_CTL_B, m_b);
         m_a = 8'h20 | ((s / 8) << 4) | ch;
         wr(adc_sel_pkg::OFF_CTL_A, m_a);
         rd(adc_sel_pkg::OFF_CTL_B, q);
         chk_read(q, m_b);
         chk_port({INT_SRC_SEL_OUT, EXT_CHAN_SEL_OUT}, 1 << k);
         wr(adc_sel_pkg::OFF_CTL_A, m_a | 8'h80);
         rd(adc_sel_pkg::OFF_CTL_A, q);
         chk_read(q, m_a | 8'h40);
         chk_port({SAMPLE_OUT, DAC_CODE_OUT}, 32'h1800);
         for (n = 0; n < 200 && q[6] !== 1'b0; n++) begin
            rd(adc_sel_pkg::OFF_CTL_A, q);
         end
         chk_read(q, m_a);
         chk_port({SAMPLE_OUT, DAC_CODE_OUT}, lv);
         m_res = lv;
         chk_results();
      end
      // abort in mid-conversion leaves the old result
      wr(adc_sel_pkg::OFF_CTL_A, m_a | 8'h80);
      levels <= ~levels;
      rd(adc_sel_pkg::OFF_CTL_A, q);
      chk_read(q, m_a | 8'h40);
      m_a = m_a & 8'h1F;
      wr(adc_sel_pkg::OFF_CTL_A, m_a);
      rd(adc_sel_pkg::OFF_CTL_A, q);
      chk_read(q, m_a);
      repeat (200) @(posedge CLK_IN);
      chk_port(CONV_POWER_OUT, 0);
      chk_results();
      // start while disabled is ignored
      wr(adc_sel_pkg::OFF_CTL_A, m_a | 8'h80);
      rd(adc_sel_pkg::OFF_CTL_A, q);
      chk_read(q, m_a);
      repeat (200) @(posedge CLK_IN);
      chk_results();
      finish_test();
   end
endmodule

// >>> verif/adc_source_model.sv
// Purpose: far-side model of the analog sources and the comparator
// Assumes: switch outputs are one-hot, level n sits half an lsb above n
// Notes: with no switch closed the comparator input floats and toggles
module adc_source_model (
   input wire logic clk_in,
   input wire logic [7:0] ext_sel_in,
   input wire logic [5:0] int_sel_in,
   input wire logic [11:0] dac_in,
   input wire logic [13:0][11:0] level_in,
   output logic comp_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic toggle_q = 1'b0; // floating node pattern
   logic [11:0] lvl; // level on the shared mux
   logic hit; // some switch is closed
   // a floating node never holds a steady value
   always @(posedge clk_in) begin
      toggle_q <= ~toggle_q;
   end
   always_comb begin
      lvl = 12'h000;
      hit = 1'b0;
      for (int k = 0; k < 6; k++) begin
         if (int_sel_in[k] && !hit) begin
            lvl = level_in[8 + k];
            hit = 1'b1;
         end
      end
      for (int k = 0; k < 8; k++) begin
         if (ext_sel_in[k] && !hit) begin
            lvl = level_in[k];
            hit = 1'b1;
         end
      end
      // high while the input stands above the trial code
      comp_out = hit ? (lvl >= dac_in) : toggle_q;
   end
endmodule
